// file: gpdfr_defines.svh
// Offsets, field positions, reset values and timing counts for the shutdown/fault block
`ifndef GPDFR_DEFINES_SVH
`define GPDFR_DEFINES_SVH
// Clock rate
`define GPDFR_CLK_MHZ            100
// Register byte offsets
`define GPDFR_OFF_CTRL           12'h000
`define GPDFR_OFF_GROUPS         12'h004
`define GPDFR_OFF_DELAYS         12'h008
`define GPDFR_OFF_FAULT_CFG      12'h00c
`define GPDFR_OFF_STATUS         12'h010
`define GPDFR_OFF_FAULT_ACT      12'h014
// Control register fields
`define GPDFR_CTRL_STYLE_BIT     0
`define GPDFR_CTRL_GO_BIT        1
// Delay register fields
`define GPDFR_DLY_GAP_LSB        0
`define GPDFR_DLY_RST_LSB        8
`define GPDFR_DLY_HOLD_LSB       10
// Fault config fields (per regulator, 3 regulators)
`define GPDFR_FC_CURRENT_LIMIT_FAULT_LSB        0
`define GPDFR_FC_OV_LSB          4
`define GPDFR_FC_UV_LSB          8
`define GPDFR_FC_REN_LSB         12
// Reset values
`define GPDFR_RST_CTRL           32'h0000_0000
`define GPDFR_RST_GROUPS         32'h0000_0300
`define GPDFR_RST_DELAYS         32'h0000_0000
`define GPDFR_RST_FAULT_CFG      32'h0000_0000
// Times in whole microseconds
`define GPDFR_GAP0_US            120
`define GPDFR_GAP1_US            250
`define GPDFR_GAP2_US            500
`define GPDFR_GAP3_US            1000
`define GPDFR_RST1_US            10
`define GPDFR_RST2_US            100
`define GPDFR_RST3_US            500
`define GPDFR_HOLD1_US           1500
`define GPDFR_HOLD2_US           5000
`define GPDFR_HOLD3_US           10000
`define GPDFR_CURRENT_LIMIT_FAULT_DB_US         1000
`define GPDFR_OVUV_PERSIST_US    300
`define GPDFR_REEN_WAIT_US       500
// Derived cycle counts
`define GPDFR_CYC(us)            ((us) * `GPDFR_CLK_MHZ)
`endif

// file: gpdfr_pkg.sv
// Types shared by the shutdown sequencer and the fault filter
package gpdfr_pkg;
  // One regulator's raw fault inputs
  typedef struct packed {
    logic current_limit_fault;
    logic ov;
    logic uv;
  } gpdfr_flt_t;
  // One regulator's fault response setup
  typedef struct packed {
    logic current_limit_fault_keep;
    logic ov_keep;
    logic uv_keep;
    logic reen;
  } gpdfr_fcfg_t;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    GPDFR_IDLE  = 6'b000001,
    GPDFR_SCAN  = 6'b000010,
    GPDFR_RSTW  = 6'b000100,
    GPDFR_OFF   = 6'b001000,
    GPDFR_GAP   = 6'b010000,
    GPDFR_HOLD  = 6'b100000
  } gpdfr_state_t;
endpackage : gpdfr_pkg

// file: gpdfr_fault_ch.sv
// One regulator's fault debounce and keep-on/disable response
`include "gpdfr_defines.svh"
module gpdfr_fault_ch #(
  parameter int CURRENT_LIMIT_FAULT_CYC    = `GPDFR_CYC(`GPDFR_CURRENT_LIMIT_FAULT_DB_US),
  parameter int PERSIST_CYC = `GPDFR_CYC(`GPDFR_OVUV_PERSIST_US),
  parameter int REEN_CYC    = `GPDFR_CYC(`GPDFR_REEN_WAIT_US)
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Monitoring window and inputs
  input  wire logic              monitor_en,
  input  wire gpdfr_pkg::gpdfr_flt_t  flt,
  input  wire gpdfr_pkg::gpdfr_fcfg_t cfg,
  // Results
  output logic                   fault_evt,
  output logic                   force_off
);
  import gpdfr_pkg::*;
  logic [19:0] current_limit_fault_cnt_q;         // Current-limit debounce counter
  logic [19:0] ovuv_cnt_q;         // OV/UV persistence counter
  logic [19:0] reen_cnt_q;         // Wait after fault clears
  logic        current_limit_fault_det_q;         // Debounced current limit
  logic        ovuv_det_q;         // Detected OV/UV (filter assumed upstream)
  logic        off_q;              // Regulator held off
  logic        ovuv_now;
  logic        current_limit_fault_trip;
  logic        ovuv_trip;
  logic        any_fault;
  assign ovuv_now  = monitor_en & (flt.ov | flt.uv);
  assign any_fault = (monitor_en & flt.current_limit_fault) | ovuv_now;
  // Current limit counted only after a full debounce
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !(monitor_en && flt.current_limit_fault))
    begin
      current_limit_fault_cnt_q <= 20'h0_0000;
      current_limit_fault_det_q <= 1'b0;
    end
    else if (current_limit_fault_cnt_q < 20'(CURRENT_LIMIT_FAULT_CYC - 1))
      current_limit_fault_cnt_q <= current_limit_fault_cnt_q + 20'h0_0001;
    else
      current_limit_fault_det_q <= 1'b1;
  end
  // OV/UV persistence timer starts the cycle the fault is detected
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !ovuv_now)
    begin
      ovuv_cnt_q <= 20'h0_0000;
      ovuv_det_q <= 1'b0;
    end
    else
    begin
      ovuv_det_q <= 1'b1;
      if (ovuv_cnt_q <= 20'(PERSIST_CYC))
        ovuv_cnt_q <= ovuv_cnt_q + 20'h0_0001;
    end
  end
  // Trip only when configured to disable
  assign current_limit_fault_trip = current_limit_fault_det_q & ~cfg.current_limit_fault_keep;
  assign ovuv_trip = (ovuv_cnt_q > 20'(PERSIST_CYC)) &
                     ((flt.ov & ~cfg.ov_keep) | (flt.uv & ~cfg.uv_keep));
  // Hold off, then release after the re-enable wait if allowed
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      off_q      <= 1'b0;
      reen_cnt_q <= 20'h0_0000;
    end
    else if (current_limit_fault_trip || ovuv_trip)
    begin
      off_q      <= 1'b1;
      reen_cnt_q <= 20'h0_0000;
    end
    else if (off_q && cfg.reen && !any_fault)
    begin
      // Restore previous state only after the fault stays gone
      if (reen_cnt_q >= 20'(REEN_CYC - 1))
        off_q <= 1'b0;
      else
        reen_cnt_q <= reen_cnt_q + 20'h0_0001;
    end
    else
      reen_cnt_q <= 20'h0_0000; // Stays off without re-enable
  end
  // Event pulse when a fault is detected while no fault was detected the cycle before
  logic det_prev_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      det_prev_q <= 1'b0;
    else
      det_prev_q <= current_limit_fault_det_q | ovuv_det_q;
  end
  assign fault_evt = (current_limit_fault_det_q | ovuv_det_q) & ~det_prev_q;
  assign force_off = off_q;
endmodule : gpdfr_fault_ch

// file: gpdfr_top.sv
// Group shutdown sequencer, power-on masking and fault response with APB registers
//
// Contract
// - Style select one chooses group shutdown
// - Group members switch off together
// - Groups run four, three, two, one
// - Empty groups skipped, timer starts populated
// - Group code 00..11 maps groups 4..1
// - Power-ok general output follows own group
// - Per-group gap 120/250/500/1000 us
// - Reset-to-disable delay none/10/100/500 us
// - Zero delay disables with reset assertion
// - Power-on ignored through sequence and hold
// - Hold delay none/1.5/5/10 ms
// - After hold, valid power-on restarts
// - Hold delay field resets to 00
// - Faults watched in active states
// - Unmasked faults assert interrupt output
// - Fault config restored after start-up
// - Keep-on bit zero disables regulator
// - Current limit debounced 1 ms, immediate off
// - OV/UV off after 300 us persistence
// - Re-enable bit chooses restore or off
// - Re-enable one restores, zero stays off
`include "gpdfr_defines.svh"
module gpdfr_top #(
  parameter int NREG = 3                      // Regulators
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // System events
  input  wire logic              power_on_input,
  input  wire logic              startup_done,
  input  wire logic              active_state,
  input  wire logic              gpo_mode,
  // Fault monitors
  input  wire gpdfr_pkg::gpdfr_flt_t [NREG-1:0] flt,
  // Outputs
  output logic [NREG-1:0]        reg_enable,
  output logic                   power_ok_pin,
  output logic                   host_reset_output,
  output logic                   interrupt_output_n,
  output logic                   startup_req
);
  import gpdfr_pkg::*;
  localparam int GAP0 = `GPDFR_CYC(`GPDFR_GAP0_US);
  localparam int GAP1 = `GPDFR_CYC(`GPDFR_GAP1_US);
  localparam int GAP2 = `GPDFR_CYC(`GPDFR_GAP2_US);
  localparam int GAP3 = `GPDFR_CYC(`GPDFR_GAP3_US);
  localparam int RST1 = `GPDFR_CYC(`GPDFR_RST1_US);
  localparam int RST2 = `GPDFR_CYC(`GPDFR_RST2_US);
  localparam int RST3 = `GPDFR_CYC(`GPDFR_RST3_US);
  localparam int HLD1 = `GPDFR_CYC(`GPDFR_HOLD1_US);
  localparam int HLD2 = `GPDFR_CYC(`GPDFR_HOLD2_US);
  localparam int HLD3 = `GPDFR_CYC(`GPDFR_HOLD3_US);
  // Registers
  logic [31:0]  ctrl_q;            // Style select, software shutdown request
  logic [31:0]  groups_q;          // 2-bit group fields: regs, power-ok, host reset
  logic [31:0]  delays_q;          // Gap, reset delay, hold delay
  logic [31:0]  fcfg_q;            // Fault keep-on and re-enable bits
  logic [NREG-1:0] flt_sticky_q;   // Fault events seen
  logic [NREG-1:0] flt_mask_q;     // Fault interrupt masks
  // Sequencer
  gpdfr_state_t state_q;
  logic [1:0]   grp_q;             // Current group code, 00 first
  logic [19:0]  tmr_q;             // Shared delay timer
  logic [NREG-1:0] seq_off_q;      // Regulators shut by the sequencer
  logic         pok_off_q;         // Power-ok general output dropped
  logic         rst_asserted_q;    // Host reset asserted by sequencer
  logic         pon_prev_q;        // Previous power-on sample
  logic         start_q;           // Start pulse request
  // Per-regulator fault channel results
  logic [NREG-1:0] fevt;
  logic [NREG-1:0] foff;
  // APB decode
  logic         wr_en;
  logic         rd_en;
  logic         addr_ok;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;           // Zero wait states
  assign addr_ok = (paddr == `GPDFR_OFF_CTRL) || (paddr == `GPDFR_OFF_GROUPS) ||
                   (paddr == `GPDFR_OFF_DELAYS) || (paddr == `GPDFR_OFF_FAULT_CFG) ||
                   (paddr == `GPDFR_OFF_STATUS) || (paddr == `GPDFR_OFF_FAULT_ACT);
  assign pslverr = psel & penable & ~addr_ok;
  // Configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctrl_q   <= `GPDFR_RST_CTRL;
      groups_q <= `GPDFR_RST_GROUPS;
      delays_q <= `GPDFR_RST_DELAYS;   // Hold field 00
    end
    else
    begin
      if (wr_en && paddr == `GPDFR_OFF_CTRL)
        ctrl_q <= pwdata & 32'h0000_0003;
      else if (state_q == GPDFR_SCAN)
        ctrl_q[`GPDFR_CTRL_GO_BIT] <= 1'b0;   // Request consumed
      if (wr_en && paddr == `GPDFR_OFF_GROUPS)
        groups_q <= pwdata & 32'h0000_0fff;
      if (wr_en && paddr == `GPDFR_OFF_DELAYS)
        delays_q <= pwdata & 32'h0000_0fff;
    end
  end
  // Fault setup: software writes, start-up completion restores defaults
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || startup_done)
    begin
      fcfg_q     <= `GPDFR_RST_FAULT_CFG;
      flt_mask_q <= '0;
    end
    else if (wr_en && paddr == `GPDFR_OFF_FAULT_CFG)
    begin
      fcfg_q     <= pwdata & 32'h0000_ffff;
      flt_mask_q <= pwdata[16 +: NREG];
    end
  end
  // Sticky fault bits: write one to clear, a new event wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      flt_sticky_q <= '0;
    else
      flt_sticky_q <= (flt_sticky_q &
                       ~((wr_en && paddr == `GPDFR_OFF_STATUS) ? pwdata[NREG-1:0] : '0))
                      | fevt;
  end
  assign interrupt_output_n = ~|(flt_sticky_q & ~flt_mask_q);
  // Read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      case (paddr)
        `GPDFR_OFF_CTRL:      prdata = ctrl_q;
        `GPDFR_OFF_GROUPS:    prdata = groups_q;
        `GPDFR_OFF_DELAYS:    prdata = delays_q;
        `GPDFR_OFF_FAULT_CFG: prdata = fcfg_q | {13'h0000, flt_mask_q, 16'h0000};
        `GPDFR_OFF_STATUS:    prdata = {20'h0_0000, 6'(state_q), 3'h0, flt_sticky_q};
        `GPDFR_OFF_FAULT_ACT: prdata = {28'h000_0000, 1'b0, foff};
        default:              prdata = 32'h0000_0000;
      endcase
    end
  end
  // Group membership for current group
  logic [NREG-1:0] reg_in_grp;
  logic            pok_in_grp;
  logic            rst_in_grp;
  logic            grp_nonempty;
  logic [1:0]      rst_code;
  always_comb
  begin
    // Field code equal to group index: 00 is group 4, 11 is group 1
    for (int i = 0; i < NREG; i++)
      reg_in_grp[i] = (groups_q[2*i +: 2] == grp_q);
    pok_in_grp   = gpo_mode && (groups_q[8 +: 2] == grp_q);
    rst_in_grp   = (groups_q[10 +: 2] == grp_q);
    grp_nonempty = (|reg_in_grp) | pok_in_grp | rst_in_grp;
    rst_code     = delays_q[`GPDFR_DLY_RST_LSB +: 2];
  end
  // Gap and hold lookups
  logic [19:0] gap_cyc;
  logic [19:0] rst_cyc;
  logic [19:0] hold_cyc;
  always_comb
  begin
    case (delays_q[`GPDFR_DLY_GAP_LSB + 2*grp_q +: 2])
      2'h0:    gap_cyc = 20'(GAP0);
      2'h1:    gap_cyc = 20'(GAP1);
      2'h2:    gap_cyc = 20'(GAP2);
      default: gap_cyc = 20'(GAP3);
    endcase
    case (rst_code)
      2'h1:    rst_cyc = 20'(RST1);
      2'h2:    rst_cyc = 20'(RST2);
      default: rst_cyc = 20'(RST3);
    endcase
    case (delays_q[`GPDFR_DLY_HOLD_LSB +: 2])
      2'h0:    hold_cyc = 20'h0_0000;
      2'h1:    hold_cyc = 20'(HLD1);
      2'h2:    hold_cyc = 20'(HLD2);
      default: hold_cyc = 20'(HLD3);
    endcase
  end
  // Shutdown triggers: power-on falling edge or software request in group style
  logic pon_fall;
  logic go;
  assign pon_fall = pon_prev_q & ~power_on_input;
  assign go = ctrl_q[`GPDFR_CTRL_STYLE_BIT] &
              (pon_fall | ctrl_q[`GPDFR_CTRL_GO_BIT]);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      pon_prev_q <= 1'b0;
    else
      pon_prev_q <= power_on_input;
  end
  // Group sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q        <= GPDFR_IDLE;
      grp_q          <= 2'h0;
      tmr_q          <= 20'h0_0000;
      seq_off_q      <= '0;
      pok_off_q      <= 1'b0;
      rst_asserted_q <= 1'b0;
      start_q        <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        GPDFR_IDLE:
        begin
          if (go)
          begin
            grp_q   <= 2'h0;                 // Group 4 first
            state_q <= GPDFR_SCAN;
          end
        end
        GPDFR_SCAN:
        begin
          tmr_q <= 20'h0_0000;
          if (!grp_nonempty)
          begin
            // Empty group: no timer spent on it
            if (grp_q == 2'h3)
              state_q <= GPDFR_HOLD;
            else
              grp_q <= grp_q + 2'h1;
          end
          else if (rst_in_grp && rst_code != 2'h0)
          begin
            rst_asserted_q <= 1'b1;          // Reset first, then wait
            state_q        <= GPDFR_RSTW;
          end
          else
          begin
            if (rst_in_grp)
              rst_asserted_q <= 1'b1;        // Same cycle as disables
            seq_off_q <= seq_off_q | reg_in_grp;
            pok_off_q <= pok_off_q | pok_in_grp;
            state_q   <= GPDFR_GAP;
          end
        end
        GPDFR_RSTW:
        begin
          if (tmr_q >= rst_cyc - 20'h0_0001)
          begin
            seq_off_q <= seq_off_q | reg_in_grp;
            pok_off_q <= pok_off_q | pok_in_grp;
            tmr_q     <= 20'h0_0000;
            state_q   <= GPDFR_GAP;
          end
          else
            tmr_q <= tmr_q + 20'h0_0001;
        end
        GPDFR_GAP:
        begin
          if (tmr_q >= gap_cyc - 20'h0_0001)
          begin
            tmr_q <= 20'h0_0000;
            if (grp_q == 2'h3)
              state_q <= GPDFR_HOLD;
            else
            begin
              grp_q   <= grp_q + 2'h1;
              state_q <= GPDFR_SCAN;
            end
          end
          else
            tmr_q <= tmr_q + 20'h0_0001;
        end
        GPDFR_HOLD:
        begin
          // Power-on is not looked at until the hold ends
          if (tmr_q >= hold_cyc)
          begin
            tmr_q   <= 20'h0_0000;
            state_q <= GPDFR_OFF;
          end
          else
            tmr_q <= tmr_q + 20'h0_0001;
        end
        GPDFR_OFF:
        begin
          if (power_on_input)
          begin
            // Valid power-up after hold restarts; outputs restored
            start_q        <= 1'b1;
            seq_off_q      <= '0;
            pok_off_q      <= 1'b0;
            rst_asserted_q <= 1'b0;
            state_q        <= GPDFR_IDLE;
          end
        end
        default: state_q <= GPDFR_IDLE;
      endcase
    end
  end
  assign startup_req       = start_q;
  assign host_reset_output = ~rst_asserted_q;     // High while released
  assign power_ok_pin      = gpo_mode & ~pok_off_q;
  assign reg_enable        = ~seq_off_q & ~foff;
  // Fault channels, one per regulator
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_flt
      gpdfr_fcfg_t c;
      assign c = '{current_limit_fault_keep: fcfg_q[`GPDFR_FC_CURRENT_LIMIT_FAULT_LSB + g],
                   ov_keep:   fcfg_q[`GPDFR_FC_OV_LSB + g],
                   uv_keep:   fcfg_q[`GPDFR_FC_UV_LSB + g],
                   reen:      fcfg_q[`GPDFR_FC_REN_LSB + g]};
      gpdfr_fault_ch u_ch (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .monitor_en (active_state),
        .flt        (flt[g]),
        .cfg        (c),
        .fault_evt  (fevt[g]),
        .force_off  (foff[g])
      );
    end
  endgenerate
  // Checks
  a_order_grp: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(grp_q) |-> grp_q == $past(grp_q) + 2'h1)
    else $error("group order broken");
  a_pon_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == GPDFR_HOLD) |=> !startup_req)
    else $error("power-on taken during hold");
  a_irq_out: assert property (@(posedge core_clk) disable iff (!rst_b)
    (|(fevt & ~flt_mask_q) && !(wr_en && paddr == `GPDFR_OFF_FAULT_CFG))
    |=> !interrupt_output_n)
    else $error("interrupt not raised");
  a_zero_rst: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == GPDFR_SCAN && rst_in_grp && rst_code == 2'h0 && grp_nonempty)
    |=> !host_reset_output && state_q == GPDFR_GAP)
    else $error("reset and disables not together");
  a_style_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == GPDFR_IDLE && !ctrl_q[`GPDFR_CTRL_STYLE_BIT]) |=> state_q == GPDFR_IDLE)
    else $error("group style started when not selected");
  a_skip_empty: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == GPDFR_SCAN && !grp_nonempty && grp_q != 2'h3) |=> state_q == GPDFR_SCAN)
    else $error("empty group not skipped");
  a_fcfg_restore: assert property (@(posedge core_clk) disable iff (!rst_b)
    startup_done |=> fcfg_q == `GPDFR_RST_FAULT_CFG)
    else $error("fault config not restored");
  a_group_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == GPDFR_GAP && $past(state_q) != GPDFR_GAP) |-> &(seq_off_q | ~reg_in_grp))
    else $error("group member left on");
endmodule : gpdfr_top

// file: gpdfr_top_tb.sv
// Self-checking bench for the group shutdown sequencer and fault response block
module gpdfr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpdfr_pkg::*;
  logic             core_clk = 1'b0;  // 100 MHz clock
  logic             rst_b = 1'b0;     // Sync reset, active low
  logic             psel = 1'b0;      // APB select
  logic             penable = 1'b0;   // APB access phase
  logic             pwrite = 1'b0;    // APB direction
  logic [11:0]      paddr = '0;       // APB byte address
  logic [31:0]      pwdata = '0;      // APB write data
  logic             power_on_input = 1'b1; // Power-on level
  logic             startup_done = 1'b0;   // Start-up finished pulse
  logic             active_state = 1'b0;   // Fault monitoring window
  gpdfr_flt_t [2:0] flt = '0;         // Raw fault levels
  logic             pready, pslverr, power_ok_pin, host_reset_output;
  logic             interrupt_output_n, startup_req;
  logic [31:0]      prdata;           // APB read data
  logic [2:0]       reg_enable;       // Regulator enables
  wire  [4:0]       obs = {host_reset_output, power_ok_pin, reg_enable}; // Shutdown outputs
  int               n_fail = 0;       // Mismatches
  int               n_tests = 0;      // Comparisons
  int               n_sr = 0;         // Start-up requests seen
  int               n;                // Cycles between output steps
  logic [31:0]      r;                // Scratch read data
  logic             e;                // Scratch error flag
  gpdfr_top DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .power_on_input(power_on_input), .startup_done(startup_done),
    .active_state(active_state), .gpo_mode(1'b1), .flt(flt), .reg_enable(reg_enable),
    .power_ok_pin(power_ok_pin), .host_reset_output(host_reset_output),
    .interrupt_output_n(interrupt_output_n), .startup_req(startup_req));
  // Free-running clock
  always #5 core_clk = ~core_clk;
  // Count start-up pulses so an early restart cannot slip past unseen
  always @(posedge core_clk)
    if (startup_req === 1'b1)
      n_sr <= n_sr + 1;
  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Cycle count compare, within a window
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("wrong value at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask : chk_rng
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
    begin
      n_fail++;
      end_of_test();
    end
  endtask : apb
  // Wait, bounded, until the shutdown outputs change
  task automatic wt();
    logic [4:0] p;
    p = obs;
    n = 0;
    while (obs === p)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 31000)
      begin
        n_fail++;
        end_of_test();
      end
    end
  endtask : wt
  // Drive the power-on level at a clock edge
  task automatic pwr(input logic v);
    @(posedge core_clk);
    power_on_input <= v;
  endtask : pwr
  // Reset values and an unmapped access
  task automatic t_regs();
    apb(1'b0, 12'h004, '0);
    chk(r, 32'h0000_0300, "group reset");
    apb(1'b0, 12'h008, '0);
    chk(r[11:10], 2'h0, "hold delay reset");
    apb(1'b0, 12'h020, '0);
    chk({31'h0, e}, 32'h1, "unmapped error");
  endtask : t_regs
  // Sequential style must not run the group sequencer
  task automatic t_style0();
    apb(1'b1, 12'h004, 32'h0000_0d30);
    pwr(1'b0);
    repeat (100) @(posedge core_clk);
    chk(obs, 5'h1f, "no group shutdown");
    pwr(1'b1);
  endtask : t_style0
  // Groups 4, 3, empty 2, then 1 together with the host reset
  task automatic t_groups();
    apb(1'b1, 12'h000, 32'h1);
    pwr(1'b0);
    wt();
    chk(obs, 5'h1c, "group 4 off together");
    pwr(1'b1);
    wt();
    chk(obs, 5'h14, "power-ok at own group");
    chk_rng(n + 1, 11995, 12010, "group gap");
    wt();
    chk(obs, 5'h00, "reset with group 1");
    chk_rng(n, 11995, 12010, "empty group skipped");
    chk(n_sr, 0, "power-on masked");
    // Last group's gap must run out before the hold and the restart
    repeat (12030) @(posedge core_clk);
    chk(n_sr, 1, "restart after hold");
    chk(obs, 5'h1f, "outputs restored");
  endtask : t_groups
  // Host reset leads its group by the selected delay
  task automatic t_rstdly();
    apb(1'b1, 12'h004, 32'h0000_0f3f);
    apb(1'b1, 12'h008, 32'h0000_0100);
    pwr(1'b0);
    wt();
    chk(obs, 5'h0f, "host reset first");
    wt();
    chk(obs, 5'h00, "group 1 after delay");
    chk_rng(n, 998, 1004, "reset delay");
    pwr(1'b1);
    repeat (12030) @(posedge core_clk);
    chk(n_sr, 2, "second restart");
  endtask : t_rstdly
  // Fault response: ignored when idle, disable, keep-on, mask and clear
  task automatic t_fault();
    apb(1'b1, 12'h00c, 32'h0007_7777);
    @(posedge core_clk);
    startup_done <= 1'b1;
    @(posedge core_clk);
    startup_done <= 1'b0;
    apb(1'b0, 12'h00c, '0);
    chk(r, 32'h0, "config restored");
    @(posedge core_clk);
    flt[0].uv <= 1'b1;
    repeat (20) @(posedge core_clk);
    flt[0].uv <= 1'b0;
    apb(1'b0, 12'h010, '0);
    chk(r[2:0], 3'h0, "no fault outside window");
    apb(1'b1, 12'h00c, 32'h0000_0757);
    active_state <= 1'b1;
    flt[1].ov <= 1'b1;
    flt[2].uv <= 1'b1;
    repeat (29990) @(posedge core_clk);
    #1;
    chk(obs, 5'h1f, "no early off");
    wt();
    chk(obs, 5'h1d, "ov off, uv kept on");
    chk_rng(n, 1, 30, "persistence");
    chk(interrupt_output_n, 1'b0, "interrupt set");
    apb(1'b0, 12'h010, '0);
    chk(r[2:0], 3'h6, "sticky faults");
    apb(1'b1, 12'h00c, 32'h0006_0757);
    // Mask lands at the access edge; look one edge later
    @(posedge core_clk);
    chk(interrupt_output_n, 1'b1, "masked");
    flt <= '0;
    apb(1'b1, 12'h00c, 32'h0000_0757);
    apb(1'b1, 12'h010, 32'h6);
    apb(1'b0, 12'h010, '0);
    chk(r[2:0], 3'h0, "faults cleared");
    repeat (200) @(posedge core_clk);
    chk(obs, 5'h1d, "stays off");
  endtask : t_fault
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_style0();
    t_groups();
    t_rstdly();
    t_fault();
    end_of_test();
  end
endmodule : gpdfr_top_tb
